// File: design/cache_op_pkg.sv
// Shared constants and types for the cache-operation capability check
package cache_op_pkg;

  localparam int ADDR_W = 32;
  localparam int CAUSE_W = 5;
  localparam int TYPE_W = 4;
  localparam int APB_AW = 12;
  localparam int EVT_W = 4;

  // Cache-management and prefetch operations from the pipeline
  typedef enum logic [2:0] {
    OP_INVAL,
    OP_ZERO,
    OP_PF_I,
    OP_PF_R,
    OP_PF_W
  } cache_op_e;

  // Request kinds toward the cache hierarchy
  typedef enum logic [2:0] {
    MEM_INVAL,
    MEM_FLUSH,
    MEM_ZERO,
    MEM_PF_I,
    MEM_PF_R,
    MEM_PF_W
  } mem_kind_e;

  localparam logic [1:0] PRIV_U = 2'h0;
  localparam logic [1:0] PRIV_S = 2'h1;

  // Violation codes written to the cause field; values are arbitrary
  localparam logic [CAUSE_W-1:0] CAUSE_NONE = 5'h00;
  localparam logic [CAUSE_W-1:0] CAUSE_TAG = 5'h02;
  localparam logic [CAUSE_W-1:0] CAUSE_SEAL = 5'h03;
  localparam logic [CAUSE_W-1:0] CAUSE_PERM = 5'h11;
  localparam logic [CAUSE_W-1:0] CAUSE_LEN = 5'h01;
  // Data-fault code for the trap value type field; value is arbitrary
  localparam logic [TYPE_W-1:0] FAULT_TYPE_DATA = 4'h1;

  // Register map
  localparam logic [APB_AW-1:0] REG_CTRL = 12'h000;
  localparam logic [APB_AW-1:0] REG_STATUS = 12'h004;
  localparam logic [APB_AW-1:0] REG_MASK = 12'h008;
  localparam logic [APB_AW-1:0] REG_FAULT = 12'h00C;

  // Control fields
  localparam int CTRL_MFLUSH_BIT = 0;
  localparam int CTRL_SFLUSH_BIT = 1;
  localparam int CTRL_PF_EN_BIT = 2;
  localparam int CTRL_W = 3;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 3'h4;

  // Status and mask fields
  localparam int ST_FAULT_BIT = 0;
  localparam int ST_PF_DROP_BIT = 1;
  localparam int ST_BAD_ENC_BIT = 2;
  localparam int ST_DONE_BIT = 3;
  localparam logic [EVT_W-1:0] EVT_RESET = 4'h0;

  // Fault information fields
  localparam int FI_CAUSE_LSB = 0;
  localparam int FI_TYPE_LSB = 8;

  typedef struct packed {
    logic tag;
    logic sealed;
    logic perm_r;
    logic perm_w;
    logic perm_x;
    logic sys_reg_access_perm;
    logic [ADDR_W-1:0] base;
    logic [ADDR_W:0] top;
    logic [ADDR_W-1:0] addr;
  } cap_s;

  typedef struct packed {
    cache_op_e op;
    logic cap_mode;
    logic [1:0] priv;
    cap_s cap_base_operand;
    logic [ADDR_W-1:0] int_addr;
    logic [11:0] imm;
  } req_s;

  typedef struct packed {
    logic valid;
    mem_kind_e kind;
    logic [ADDR_W-1:0] addr;
    logic clr_tag;
  } mem_req_s;

  typedef struct packed {
    logic done;
    logic fault;
    logic [CAUSE_W-1:0] cause;
    logic [TYPE_W-1:0] ftype;
  } resp_s;

endpackage

// File: design/cache_op_capability_check.sv
// Capability authorisation and fault logic for cache-block and prefetch operations
`timescale 1ns/1ps

module cache_op_capability_check
  import cache_op_pkg::*;
#(
  parameter int block_bytes = 64,
  parameter int cap_width_bits = 64
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // APB register port
  input wire logic [APB_AW-1:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Pipeline side
  input wire logic req_valid_i,
  input wire req_s req_i,
  input wire cap_s ddc_i,
  output logic req_ready_o,
  output resp_s resp_o,
  // Cache side
  output mem_req_s mem_req_o,
  input wire logic mem_ready_i,
  // Interrupt
  output logic irq_o
);

  localparam int BLK_LSB = $clog2(block_bytes);
  localparam int CHUNK_BYTES = cap_width_bits / 8;
  localparam int CHUNKS = block_bytes / CHUNK_BYTES;
  localparam int CNT_W = $clog2(CHUNKS) + 1;
  localparam logic [CNT_W-1:0] LAST_CHUNK = CNT_W'(CHUNKS - 1);
  localparam logic [ADDR_W:0] BLK_SPAN = (ADDR_W + 1)'(block_bytes);
  localparam logic [ADDR_W-1:0] CHUNK_STEP = ADDR_W'(CHUNK_BYTES);

  typedef enum logic {ST_IDLE, ST_ISSUE} fsm_e;

  fsm_e state;
  fsm_e next_state;
  mem_req_s next_mem;
  resp_s next_resp;
  logic [CNT_W-1:0] chunks_left;
  logic [CNT_W-1:0] next_chunks;

  logic [CTRL_W-1:0] ctrl;
  logic [EVT_W-1:0] status;
  logic [EVT_W-1:0] next_status;
  logic [EVT_W-1:0] mask;
  logic [EVT_W-1:0] events;
  logic [CAUSE_W-1:0] last_cause;
  logic [TYPE_W-1:0] last_type;

  cap_s auth;
  logic [ADDR_W-1:0] base_addr;
  logic [ADDR_W-1:0] eff_addr;
  logic [ADDR_W-1:0] blk_addr;
  logic [ADDR_W:0] blk_start;
  logic [ADDR_W:0] blk_end;
  logic accept;
  logic is_pf;
  logic in_full;
  logic in_any;
  logic perm_ok;
  logic pf_enc_ok;
  logic pf_ok;
  logic inval_flush;
  logic [CAUSE_W-1:0] chk_cause;
  mem_kind_e pf_kind;

  logic apb_access;
  logic wr_fire;
  logic addr_hit;
  logic [31:0] rd_data;
  logic [31:0] wmask;

  assign accept = req_valid_i && req_ready_o;

  // Authority, address and bounds for the request in flight
  always_comb begin
    auth = req_i.cap_mode ? req_i.cap_base_operand : ddc_i;
    base_addr = req_i.cap_mode ? req_i.cap_base_operand.addr : req_i.int_addr;
    is_pf = (req_i.op == OP_PF_I) || (req_i.op == OP_PF_R) || (req_i.op == OP_PF_W);
    eff_addr = is_pf ? base_addr + {{(ADDR_W - 12){req_i.imm[11]}}, req_i.imm}
                     : base_addr;
    blk_addr = {eff_addr[ADDR_W-1:BLK_LSB], {BLK_LSB{1'b0}}};
    blk_start = {1'b0, blk_addr};
    blk_end = blk_start + BLK_SPAN;
    in_full = (blk_start >= {1'b0, auth.base}) && (blk_end <= auth.top);
    in_any = (blk_start < auth.top) && (blk_end > {1'b0, auth.base});
    pf_enc_ok = (req_i.imm[4:0] == 5'h00);
    pf_kind = MEM_PF_R;
    unique case (req_i.op)
      OP_INVAL: perm_ok = auth.perm_w && auth.perm_r && auth.sys_reg_access_perm;
      OP_ZERO: perm_ok = auth.perm_w;
      OP_PF_I: begin
        perm_ok = auth.perm_x;
        pf_kind = MEM_PF_I;
      end
      OP_PF_R: perm_ok = auth.perm_r;
      OP_PF_W: begin
        perm_ok = auth.perm_w;
        pf_kind = MEM_PF_W;
      end
      default: perm_ok = 1'b0;
    endcase
    if (!auth.tag) begin
      chk_cause = CAUSE_TAG;
    end else if (auth.sealed) begin
      chk_cause = CAUSE_SEAL;
    end else if (!perm_ok) begin
      chk_cause = CAUSE_PERM;
    end else if (!in_full) begin
      chk_cause = CAUSE_LEN;
    end else begin
      chk_cause = CAUSE_NONE;
    end
    pf_ok = auth.tag && !auth.sealed && perm_ok && in_any;
    inval_flush = ((req_i.priv == PRIV_S) && ctrl[CTRL_MFLUSH_BIT])
               || ((req_i.priv == PRIV_U)
                   && (ctrl[CTRL_MFLUSH_BIT] || ctrl[CTRL_SFLUSH_BIT]));
  end

  // Sequencing of checks and cache requests
  always_comb begin
    next_state = state;
    next_mem = mem_req_o;
    next_resp = '0;
    next_chunks = chunks_left;
    events = '0;
    unique case (state)
      ST_IDLE: begin
        if (accept) begin
          if (is_pf) begin
            if (!pf_enc_ok) begin
              next_resp.done = 1'b1;
              events[ST_BAD_ENC_BIT] = 1'b1;
            end else if (!pf_ok || !ctrl[CTRL_PF_EN_BIT]) begin
              next_resp.done = 1'b1;
              events[ST_PF_DROP_BIT] = 1'b1;
            end else begin
              next_mem = '{valid: 1'b1, kind: pf_kind, addr: blk_addr, clr_tag: 1'b0};
              next_chunks = '0;
              next_state = ST_ISSUE;
            end
          end else if (chk_cause != CAUSE_NONE) begin
            next_resp.done = 1'b1;
            next_resp.fault = 1'b1;
            next_resp.cause = chk_cause;
            next_resp.ftype = FAULT_TYPE_DATA;
            events[ST_FAULT_BIT] = 1'b1;
          end else if (req_i.op == OP_ZERO) begin
            next_mem = '{valid: 1'b1, kind: MEM_ZERO, addr: blk_addr, clr_tag: 1'b1};
            next_chunks = LAST_CHUNK;
            next_state = ST_ISSUE;
          end else begin
            next_mem.valid = 1'b1;
            next_mem.kind = inval_flush ? MEM_FLUSH : MEM_INVAL;
            next_mem.addr = blk_addr;
            next_mem.clr_tag = 1'b0;
            next_chunks = '0;
            next_state = ST_ISSUE;
          end
        end
      end
      ST_ISSUE: begin
        if (mem_ready_i) begin
          if (chunks_left != '0) begin
            next_mem.addr = mem_req_o.addr + CHUNK_STEP;
            next_chunks = chunks_left - 1'b1;
          end else begin
            next_mem.valid = 1'b0;
            next_resp.done = 1'b1;
            events[ST_DONE_BIT] = 1'b1;
            next_state = ST_IDLE;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state <= ST_IDLE;
      req_ready_o <= 1'b1;
      chunks_left <= '0;
    end else begin
      state <= next_state;
      req_ready_o <= (next_state == ST_IDLE);
      chunks_left <= next_chunks;
    end
  end

  // Request is held until the cache takes it
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mem_req_o <= '{valid: 1'b0, kind: MEM_INVAL, addr: '0, clr_tag: 1'b0};
    end else begin
      mem_req_o <= next_mem;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      resp_o <= '0;
    end else begin
      resp_o <= next_resp;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      last_cause <= CAUSE_NONE;
      last_type <= '0;
    end else if (events[ST_FAULT_BIT]) begin
      last_cause <= next_resp.cause;
      last_type <= next_resp.ftype;
    end
  end

  // APB slave with one wait state, so read data comes from a flop
  always_comb begin
    apb_access = psel_i && penable_i && !pready_o;
    wr_fire = psel_i && penable_i && pready_o && pwrite_i;
    wmask = {{8{pstrb_i[3]}}, {8{pstrb_i[2]}}, {8{pstrb_i[1]}}, {8{pstrb_i[0]}}};
    addr_hit = 1'b1;
    rd_data = '0;
    unique case (paddr_i)
      REG_CTRL: rd_data[CTRL_W-1:0] = ctrl;
      REG_STATUS: rd_data[EVT_W-1:0] = status;
      REG_MASK: rd_data[EVT_W-1:0] = mask;
      REG_FAULT: begin
        rd_data[FI_CAUSE_LSB +: CAUSE_W] = last_cause;
        rd_data[FI_TYPE_LSB +: TYPE_W] = last_type;
      end
      default: addr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pready_o <= 1'b0;
      prdata_o <= '0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o <= apb_access;
      prdata_o <= (apb_access && !pwrite_i) ? rd_data : 32'h0000_0000;
      pslverr_o <= apb_access && !addr_hit;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctrl <= CTRL_RESET;
      mask <= EVT_RESET;
    end else if (wr_fire) begin
      if (paddr_i == REG_CTRL) begin
        ctrl <= (ctrl & ~wmask[CTRL_W-1:0]) | (pwdata_i[CTRL_W-1:0] & wmask[CTRL_W-1:0]);
      end
      if (paddr_i == REG_MASK) begin
        mask <= (mask & ~wmask[EVT_W-1:0]) | (pwdata_i[EVT_W-1:0] & wmask[EVT_W-1:0]);
      end
    end
  end

  // Write-one-to-clear; a new event in the clearing cycle survives
  always_comb begin
    next_status = status;
    if (wr_fire && (paddr_i == REG_STATUS)) begin
      next_status = status & ~(pwdata_i[EVT_W-1:0] & wmask[EVT_W-1:0]);
    end
    next_status = next_status | events;
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      status <= EVT_RESET;
      irq_o <= 1'b0;
    end else begin
      status <= next_status;
      irq_o <= |(next_status & mask);
    end
  end

endmodule

// File: sim/cache_op_assertions.sv
// Concurrent checks on the cache-operation block's ports
`timescale 1ns/1ps
module cache_op_assertions
  import cache_op_pkg::*;
#(
  parameter int cap_width_bits = 64
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Pipeline and cache sides
  input wire logic req_valid_i,
  input wire req_s req_i,
  input wire cap_s ddc_i,
  input wire logic req_ready_o,
  input wire resp_s resp_o,
  input wire mem_req_s mem_req_o,
  input wire logic mem_ready_i
);
  localparam int CHUNK = cap_width_bits / 8;
  logic pf_take;
  assign pf_take = req_valid_i && req_ready_o && req_i.op inside {OP_PF_I, OP_PF_R, OP_PF_W};
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  sequence take_s(cache_op_e o);
    req_valid_i && req_ready_o && req_i.op == o;
  endsequence
  sequence fault_s(logic [CAUSE_W-1:0] c);
    resp_o.done && resp_o.fault && resp_o.cause == c && resp_o.ftype == FAULT_TYPE_DATA;
  endsequence
  inval_tag_a: assert property (
    take_s(OP_INVAL) ##0 (req_i.cap_mode && !req_i.cap_base_operand.tag) |=> fault_s(CAUSE_TAG))
    else $error("untagged invalidate not faulted");
  inval_perm_a: assert property (
    take_s(OP_INVAL) ##0 (req_i.cap_mode && req_i.cap_base_operand.tag
      && !req_i.cap_base_operand.sealed && !req_i.cap_base_operand.sys_reg_access_perm)
    |=> fault_s(CAUSE_PERM)) else $error("invalidate without permission not faulted");
  legacy_ddc_a: assert property (
    take_s(OP_INVAL) ##0 (!req_i.cap_mode && !ddc_i.tag) |=> fault_s(CAUSE_TAG))
    else $error("legacy invalidate ignored default capability");
  zero_seal_a: assert property (
    take_s(OP_ZERO) ##0 (req_i.cap_mode && req_i.cap_base_operand.tag
      && req_i.cap_base_operand.sealed) |=> fault_s(CAUSE_SEAL))
    else $error("sealed zero not faulted");
  pf_nofault_a: assert property (
    pf_take |=> !resp_o.fault [*2]) else $error("prefetch raised a fault");
  pf_badenc_a: assert property (
    pf_take && req_i.imm[4:0] != 5'h00 |=> resp_o.done && !mem_req_o.valid)
    else $error("bad prefetch encoding made an access");
  pf_untag_a: assert property (
    pf_take && req_i.cap_mode && !req_i.cap_base_operand.tag |=> !mem_req_o.valid)
    else $error("untagged prefetch made an access");
  zero_clr_a: assert property (
    mem_req_o.valid && mem_req_o.kind == MEM_ZERO |-> mem_req_o.clr_tag)
    else $error("zero write keeps the tag");
  zero_step_a: assert property (
    (mem_req_o.valid && mem_ready_i && mem_req_o.kind == MEM_ZERO)
    ##1 (mem_req_o.valid && mem_req_o.kind == MEM_ZERO)
    |-> mem_req_o.addr == $past(mem_req_o.addr) + CHUNK) else $error("zero writes not ascending");
endmodule
bind cache_op_capability_check cache_op_assertions #(.cap_width_bits(cap_width_bits))
  i_cache_op_assertions (.*);

// File: sim/cache_model.sv
// Cache-side responder, accepting at once or after a stall
`timescale 1ns/1ps
module cache_model
  import cache_op_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Block side
  input wire mem_req_s mem_req_i,
  input wire logic slow_i,
  output logic mem_ready_o
);
  // Slow mode stalls every request one cycle
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mem_ready_o <= 1'b0;
    end else begin
      mem_ready_o <= slow_i ? (mem_req_i.valid && !mem_ready_o) : 1'b1;
    end
  end
endmodule

// File: sim/testbench.sv
// Self-checking bench for the cache-operation block
`timescale 1ns/1ps
module testbench;
  import cache_op_pkg::*;
  localparam logic [31:0] A = 32'h0000_1000;
  logic clk_i = 0, rst_b_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0;
  logic req_valid_i = 0, slow = 0, pready_o, pslverr_o, req_ready_o, mem_ready_i, irq_o, err;
  logic [11:0] paddr_i = '0;
  logic [31:0] pwdata_i = '0, prdata_o, rd;
  logic [3:0] pstrb_i = 4'hf;
  req_s req_i = '0;
  cap_s ddc_i = '0, g;
  resp_s resp_o, got;
  mem_req_s mem_req_o, q[$];
  int error_cnt = 0, checks_done = 0;
  cache_op_capability_check i_cache_op_capability_check (.*);
  cache_model i_cache_model (.clk_i, .rst_b_i, .mem_req_i(mem_req_o), .slow_i(slow),
    .mem_ready_o(mem_ready_i));
  initial forever #25 clk_i = ~clk_i;
  function automatic cap_s mk(logic [5:0] f, logic [31:0] a);
    mk = '{f[5], f[4], f[3], f[2], f[1], f[0], A, 33'h0_0000_2000, a};
  endfunction
  task automatic chk(string n, logic [32:0] s, logic [32:0] e);
    checks_done++;
    if (s !== e) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", n, e, s);
    end
  endtask
  task automatic conclude;
    $display("checks %0d, mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    int n = 0;
    @(posedge clk_i);
    paddr_i <= a;
    pwrite_i <= w;
    pwdata_i <= d;
    psel_i <= 1'b1;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 50);
    if (pready_o !== 1'b1) error_cnt++;
    if (pready_o !== 1'b1) conclude();
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic run(cache_op_e o, logic m, logic [1:0] p, cap_s c, cap_s d, logic [11:0] im);
    int n = 0;
    logic t = 0;
    q.delete();
    @(posedge clk_i);
    req_i <= '{o, m, p, c, A, im};
    ddc_i <= d;
    req_valid_i <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
      if (t && mem_req_o.valid && mem_ready_i) q.push_back(mem_req_o);
      got = t ? resp_o : '0;
      if (!t && req_ready_o === 1'b1) begin
        t = 1;
        req_valid_i <= 1'b0;
      end
    end while (got.done !== 1'b1 && n < 100);
    if (got.done !== 1'b1) error_cnt++;
    if (got.done !== 1'b1) conclude();
  endtask
  task automatic expf(logic [4:0] c);
    chk("fault", got.fault, 1'b1);
    chk("cause", got.cause, c);
    chk("ftype", got.ftype, FAULT_TYPE_DATA);
    chk("accesses", q.size(), 0);
  endtask
  task automatic expa(mem_kind_e k, int cnt);
    chk("fault", got.fault, 1'b0);
    chk("accesses", q.size(), cnt);
    for (int i = 0; i < q.size(); i++) begin
      chk("kind", q[i].kind, k);
      chk("addr", q[i].addr, A + (cnt > 1 ? i * 8 : 0));
    end
  endtask
  task automatic t_regs;
    apb(0, REG_CTRL, 0);
    chk("ctrl", rd, CTRL_RESET);
    apb(0, REG_MASK, 0);
    chk("mask", rd, 0);
    apb(0, 12'h010, 0);
    chk("slverr", err, 1'b1);
    $display("registers done");
  endtask
  task automatic t_inval;
    cap_s f[4] = '{mk(6'h0f, A), mk(6'h3f, A), mk(6'h2e, A), mk(6'h2f, 32'h0000_3000)};
    logic [4:0] cz[4] = '{CAUSE_TAG, CAUSE_SEAL, CAUSE_PERM, CAUSE_LEN};
    for (int j = 0; j < 8; j++) begin
      if (j == 4) apb(1, REG_CTRL, 32'h0000_0007);
      run(OP_INVAL, 1, j < 4 ? 2'h3 : PRIV_U, f[j % 4], g, 12'h000);
      expf(cz[j % 4]);
    end
    run(OP_INVAL, 1, 2'h3, g, g, 12'h000);
    expa(MEM_INVAL, 1);
    run(OP_INVAL, 1, PRIV_S, g, g, 12'h000);
    expa(MEM_FLUSH, 1);
    apb(1, REG_CTRL, CTRL_RESET);
    run(OP_INVAL, 1, PRIV_S, g, g, 12'h000);
    expa(MEM_INVAL, 1);
    run(OP_INVAL, 0, 2'h3, g, mk(6'h0f, A), 12'h000);
    expf(CAUSE_TAG);
    apb(0, REG_FAULT, 0);
    chk("fault info", rd, (32'(FAULT_TYPE_DATA) << FI_TYPE_LSB) | 32'(CAUSE_TAG));
    $display("invalidate done");
  endtask
  task automatic t_zero;
    slow <= 1'b1;
    run(OP_ZERO, 1, 2'h3, g, g, 12'h000);
    expa(MEM_ZERO, 8);
    run(OP_ZERO, 1, 2'h3, mk(6'h3f, A), g, 12'h000);
    expf(CAUSE_SEAL);
    run(OP_ZERO, 1, 2'h3, mk(6'h2b, A), g, 12'h000);
    expf(CAUSE_PERM);
    run(OP_ZERO, 0, 2'h3, g, mk(6'h0f, A), 12'h000);
    expf(CAUSE_TAG);
    slow <= 1'b0;
    $display("zero done");
  endtask
  task automatic t_pf;
    cache_op_e o[3] = '{OP_PF_I, OP_PF_R, OP_PF_W};
    mem_kind_e k[3] = '{MEM_PF_I, MEM_PF_R, MEM_PF_W};
    logic [5:0] np[3] = '{6'h2d, 6'h27, 6'h2b};
    for (int i = 0; i < 3; i++) begin
      run(o[i], 1, PRIV_U, mk(6'h2f, 32'h0000_1040), g, 12'hfc0);
      expa(k[i], 1);
      run(o[i], 1, PRIV_U, mk(np[i], A), g, 12'h000);
      expa(k[i], 0);
      run(o[i], 1, PRIV_U, mk(6'h1f, A), g, 12'h000);
      expa(k[i], 0);
      run(o[i], 0, PRIV_U, g, g, 12'h020);
      expa(k[i], 1);
    end
    $display("prefetch done");
  endtask
  task automatic t_irq;
    apb(1, REG_STATUS, 32'h0000_000f);
    apb(1, REG_MASK, 32'h0000_0004);
    run(OP_PF_R, 1, PRIV_U, g, g, 12'h021);
    expa(MEM_PF_R, 0);
    @(posedge clk_i);
    chk("irq", irq_o, 1'b1);
    apb(0, REG_STATUS, 0);
    chk("status", rd, 32'h0000_0004);
    apb(1, REG_STATUS, 32'h0000_0004);
    @(posedge clk_i);
    chk("irq", irq_o, 1'b0);
    apb(1, REG_CTRL, 32'h0000_0000);
    run(OP_PF_W, 1, PRIV_U, g, g, 12'h000);
    expa(MEM_PF_W, 0);
    $display("interrupt done");
  endtask
  initial begin
    g = mk(6'h2f, A);
    repeat (20) @(posedge clk_i);
    rst_b_i <= 1'b1;
    t_regs();
    t_inval();
    t_zero();
    t_pf();
    t_irq();
    conclude();
  end
endmodule
